// *** hw/cal_regs_dev.sv ***
// Calibration register bank with auto-incrementing access pointer
`timescale 1ns/1ps
`default_nettype none
`include "cal_defines.svh"
module cal_regs_dev
  import cal_pkg::*;
#(
  parameter logic [`CAL_DATA_W-1:0] OFFSET_RST = `CAL_OFFSET_RST,
  parameter logic [`CAL_DATA_W-1:0] GAIN_RST   = `CAL_GAIN_RST,
  parameter logic [`CAL_DATA_W-1:0] DAC_RST    = `CAL_DAC_RST
)(
  input  wire logic                            clk_sys,
  input  wire logic                            rst,
  cal_if.dev                                   link,
  input  wire logic                            cal_upd_valid,
  input  wire logic [`CAL_IDX_W-1:0]           cal_upd_idx,
  input  wire logic [`CAL_DATA_W-1:0]          cal_upd_data,
  output logic      [`CAL_DATA_W-1:0]          gain_trim,
  output logic      [`CAL_DATA_W-1:0]          offset_trim,
  output logic      [8*`CAL_DATA_W-1:0]        dac_trim,
  output logic      [1:0]                      cal_select,
  output logic      [1:0]                      read_select,
  output logic                                 mode1,
  output logic      [`CAL_IDX_W-1:0]           cal_ptr
);

  logic [`CAL_DATA_W-1:0] trim_q [`CAL_NUM];
  logic [`CAL_IDX_W-1:0]  ptr_q;
  logic [`CAL_IDX_W-1:0]  ptr_d;
  cal_sel_t               sel_q;
  logic [1:0]             rdsel_q;
  logic                   mode1_q;
  logic                   rd_valid_q;
  logic [`CAL_WORD_W-1:0] rd_data_q;

  // Decode of the current access
  wire cal_sel_t              new_sel   = cal_sel_t'(link.ctrl_sel);
  wire logic                  rd_en     = (rdsel_q == `RDSEL_CAL);
  wire logic                  rd_hit    = link.cal_rd && rd_en;
  wire logic                  wr_hit    = link.cal_wr;
  wire logic                  access    = rd_hit || wr_hit;
  wire logic [`CAL_IDX_W-1:0] start_new = (new_sel == SEL_OFFSET) ? `CAL_IDX_OFFSET
                                                                   : `CAL_IDX_GAIN;
  wire logic [`CAL_IDX_W-1:0] start_cur = (sel_q == SEL_OFFSET) ? `CAL_IDX_OFFSET
                                                                 : `CAL_IDX_GAIN;
  // Last index of the active set; gain is index 0, so start plus length less one
  wire logic [`CAL_IDX_W-1:0] last_idx  = (sel_q == SEL_OFFSET) ? `CAL_IDX_OFFSET
                                        : (seq_len(sel_q) - 4'h1);
  wire logic                  at_last   = (ptr_q == last_idx);

  // Pointer steering
  always_comb
  begin
    ptr_d = ptr_q;
    if (link.ctrl_wr)
      ptr_d = start_new;
    else if (access && at_last)
      ptr_d = start_cur;
    else if (access)
      ptr_d = ptr_q + 4'h1;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      ptr_q <= `CAL_IDX_GAIN;
    else
      ptr_q <= ptr_d;
  end

  // Control fields captured on each control write
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sel_q   <= SEL_ALL;
      rdsel_q <= `RDSEL_DEFAULT;
    end
    else if (link.ctrl_wr)
    begin
      sel_q   <= new_sel;
      rdsel_q <= link.ctrl_rdsel;
    end
  end

  // Mode bit; a control write in the same cycle as a read keeps the new value
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      mode1_q <= 1'b0;
    else if (link.ctrl_wr)
      mode1_q <= link.ctrl_mode1;
    else if (link.cal_rd)
      mode1_q <= 1'b0;
  end

  // Register array: calibration engine update has priority over a host write,
  // since the engine runs while the host should stay off the bank.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < `CAL_NUM; i++)
        trim_q[i] <= DAC_RST;
      trim_q[`CAL_IDX_GAIN]   <= GAIN_RST;
      trim_q[`CAL_IDX_OFFSET] <= OFFSET_RST;
    end
    else if (cal_upd_valid && (cal_upd_idx <= `CAL_IDX_LAST))
      trim_q[cal_upd_idx] <= cal_upd_data;
    else if (wr_hit)
      trim_q[ptr_q] <= link.cal_wdata[`CAL_DATA_W-1:0];
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rd_valid_q <= 1'b0;
      rd_data_q  <= '0;
    end
    else
    begin
      rd_valid_q <= link.cal_rd;
      if (link.cal_rd)
        rd_data_q <= rd_en ? {2'b00, trim_q[ptr_q]} : '0;
    end
  end

  assign link.rd_valid = rd_valid_q;
  assign link.rd_data  = rd_data_q;

  // Trims go to the converter core: larger offset code adds positive
  // correction, larger gain code stretches a short span.
  assign gain_trim   = trim_q[`CAL_IDX_GAIN];
  assign offset_trim = trim_q[`CAL_IDX_OFFSET];
  for (genvar g = 0; g < 8; g++)
  begin : g_dac
    assign dac_trim[g*`CAL_DATA_W +: `CAL_DATA_W] = trim_q[g + 2];
  end
  assign cal_select  = sel_q;
  assign read_select = rdsel_q;
  assign mode1       = mode1_q;
  assign cal_ptr     = ptr_q;

endmodule
`default_nettype wire

// *** common/cal_defines.svh ***
// Offsets, field codes, reset values and counts for calibration register access
`ifndef CAL_DEFINES_SVH
`define CAL_DEFINES_SVH
`define CAL_NUM        10
`define CAL_IDX_W      4
`define CAL_DATA_W     14
`define CAL_WORD_W     16
`define CAL_IDX_GAIN   4'h0
`define CAL_IDX_OFFSET 4'h1
`define CAL_IDX_DAC0   4'h2
`define CAL_IDX_LAST   4'h9
`define CAL_LEN_ALL    4'ha
`define CAL_LEN_GO     4'h2
`define CAL_LEN_ONE    4'h1
`define CAL_OFFSET_RST 14'h2000
`define CAL_GAIN_RST   14'h2000
`define CAL_DAC_RST    14'h0000
`define RDSEL_CAL      2'h2
`define RDSEL_DEFAULT  2'h0
`endif

// *** common/cal_pkg.sv ***
// Types shared by both ends of the calibration register link
`include "cal_defines.svh"
package cal_pkg;
  typedef enum logic [1:0] {
    SEL_ALL         = 2'h0,
    SEL_GAIN_OFFSET = 2'h1,
    SEL_OFFSET      = 2'h2,
    SEL_GAIN        = 2'h3
  } cal_sel_t;

  typedef enum logic [1:0] {
    OP_START_WR = 2'h0,
    OP_START_RD = 2'h1,
    OP_WORD_WR  = 2'h2,
    OP_WORD_RD  = 2'h3
  } host_op_t;

  typedef enum logic [1:0] {
    DIR_NONE = 2'h0,
    DIR_WR   = 2'h1,
    DIR_RD   = 2'h3
  } seq_dir_t;

  typedef enum logic {
    H_IDLE = 1'b0,
    H_WAIT = 1'b1
  } host_state_t;

  function automatic logic [3:0] seq_len(input cal_sel_t sel);
    unique case (sel)
      SEL_ALL:         seq_len = `CAL_LEN_ALL;
      SEL_GAIN_OFFSET: seq_len = `CAL_LEN_GO;
      SEL_OFFSET:      seq_len = `CAL_LEN_ONE;
      SEL_GAIN:        seq_len = `CAL_LEN_ONE;
    endcase
  endfunction
endpackage

// *** common/cal_if.sv ***
// Word-level link between host controller and calibration register bank
`timescale 1ns/1ps
`default_nettype none
interface cal_if;
  logic        ctrl_wr;
  logic [1:0]  ctrl_sel;
  logic [1:0]  ctrl_rdsel;
  logic        ctrl_mode1;
  logic        cal_wr;
  logic [15:0] cal_wdata;
  logic        cal_rd;
  logic        rd_valid;
  logic [15:0] rd_data;

  modport dev (
    input  ctrl_wr, ctrl_sel, ctrl_rdsel, ctrl_mode1, cal_wr, cal_wdata, cal_rd,
    output rd_valid, rd_data
  );
  modport host (
    output ctrl_wr, ctrl_sel, ctrl_rdsel, ctrl_mode1, cal_wr, cal_wdata, cal_rd,
    input  rd_valid, rd_data
  );
endinterface
`default_nettype wire

// *** hw/cal_host.sv ***
// Host-side controller that sequences calibration register accesses
`timescale 1ns/1ps
`default_nettype none
`include "cal_defines.svh"
module cal_host
  import cal_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  cal_if.host                         link,
  input  wire logic                   req_valid,
  output logic                        req_ready,
  input  wire logic [1:0]             req_op,
  input  wire logic [1:0]             req_sel,
  input  wire logic                   req_mode1,
  input  wire logic [`CAL_DATA_W-1:0] req_wdata,
  output logic                        rsp_valid,
  output logic [`CAL_DATA_W-1:0]      rsp_data,
  output logic                        req_err
);

  host_state_t            state_q;
  seq_dir_t               dir_q;
  logic [3:0]             remain_q;
  logic                   ready_q;
  logic                   rsp_valid_q;
  logic [`CAL_DATA_W-1:0] rsp_data_q;
  logic                   err_q;
  logic                   ctrl_wr_q;
  logic [1:0]             ctrl_sel_q;
  logic [1:0]             ctrl_rdsel_q;
  logic                   ctrl_mode1_q;
  logic                   cal_wr_q;
  logic [15:0]            cal_wdata_q;
  logic                   cal_rd_q;

  wire host_op_t op       = host_op_t'(req_op);
  wire logic     take     = req_valid && ready_q && (state_q == H_IDLE);
  wire logic     locked   = (remain_q != 4'h0); // mode 1 read still open
  wire logic     is_start = (op == OP_START_WR) || (op == OP_START_RD);
  wire logic     bad      = is_start ? locked
                          : (op == OP_WORD_WR) ? (dir_q != DIR_WR)
                          : (dir_q != DIR_RD);
  wire logic     go       = take && !bad;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_q      <= H_IDLE;
      dir_q        <= DIR_NONE;
      remain_q     <= 4'h0;
      ready_q      <= 1'b0;
      err_q        <= 1'b0;
      ctrl_wr_q    <= 1'b0;
      ctrl_sel_q   <= 2'h0;
      ctrl_rdsel_q <= `RDSEL_DEFAULT;
      ctrl_mode1_q <= 1'b0;
      cal_wr_q     <= 1'b0;
      cal_wdata_q  <= '0;
      cal_rd_q     <= 1'b0;
      rsp_valid_q  <= 1'b0;
      rsp_data_q   <= '0;
    end
    else
    begin
      err_q       <= take && bad;
      ctrl_wr_q   <= go && is_start;
      cal_wr_q    <= go && (op == OP_WORD_WR);
      cal_rd_q    <= go && (op == OP_WORD_RD);
      rsp_valid_q <= 1'b0;
      ready_q     <= (state_q == H_IDLE) && !(go && (op == OP_WORD_RD));
      if (go && is_start)
      begin
        ctrl_sel_q   <= req_sel;
        ctrl_rdsel_q <= (op == OP_START_RD) ? `RDSEL_CAL : `RDSEL_DEFAULT;
        ctrl_mode1_q <= req_mode1;
        dir_q        <= (op == OP_START_RD) ? DIR_RD : DIR_WR;
        remain_q     <= (op == OP_START_RD && req_mode1)
                        ? seq_len(cal_sel_t'(req_sel)) : 4'h0;
      end
      if (go && (op == OP_WORD_WR))
        cal_wdata_q <= {2'b00, req_wdata};
      if (go && (op == OP_WORD_RD))
      begin
        state_q <= H_WAIT;
        if (locked)
          remain_q <= remain_q - 4'h1;
      end
      if ((state_q == H_WAIT) && link.rd_valid)
      begin
        state_q     <= H_IDLE;
        rsp_valid_q <= 1'b1;
        rsp_data_q  <= link.rd_data[`CAL_DATA_W-1:0];
        ready_q     <= 1'b1;
      end
    end
  end

  assign link.ctrl_wr    = ctrl_wr_q;
  assign link.ctrl_sel   = ctrl_sel_q;
  assign link.ctrl_rdsel = ctrl_rdsel_q;
  assign link.ctrl_mode1 = ctrl_mode1_q;
  assign link.cal_wr     = cal_wr_q;
  assign link.cal_wdata  = cal_wdata_q;
  assign link.cal_rd     = cal_rd_q;
  assign req_ready       = ready_q;
  assign rsp_valid       = rsp_valid_q;
  assign rsp_data        = rsp_data_q;
  assign req_err         = err_q;

endmodule
`default_nettype wire

// *** testbench/cal_asserts.sv ***
// Concurrent checks on the link between host controller and register bank
`timescale 1ns/1ps
`default_nettype none
module cal_asserts (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        ctrl_wr,
  input wire logic [1:0]  ctrl_sel,
  input wire logic [1:0]  ctrl_rdsel,
  input wire logic        ctrl_mode1,
  input wire logic        cal_wr,
  input wire logic [15:0] cal_wdata,
  input wire logic        cal_rd,
  input wire logic        rd_valid,
  input wire logic [15:0] rd_data
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [15:0] last_q;
  logic        clean_q;
  // A control or register write on the link may change the single register, so the remembered word is dropped
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      clean_q <= 1'b0;
    else if (ctrl_wr || cal_wr)
      clean_q <= 1'b0;
    else if (rd_valid)
      clean_q <= ctrl_sel[1] && (ctrl_rdsel == 2'h2);
  end
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      last_q <= 16'h0;
    else if (rd_valid)
      last_q <= rd_data;
  end
  a_read_answer: assert property (cal_rd |=> rd_valid)
    else $error("read strobe without answer");
  a_answer_cause: assert property (rd_valid |-> $past(cal_rd))
    else $error("answer without read strobe");
  a_lead_zeros: assert property (rd_valid |-> rd_data[15:14] == 2'h0)
    else $error("read word lacks leading zeros");
  a_data_holds: assert property (!rd_valid |-> $stable(rd_data))
    else $error("read word changed without a read");
  a_one_strobe: assert property ($onehot0({ctrl_wr, cal_wr, cal_rd}))
    else $error("two link strobes at once");
  a_write_silent: assert property (cal_wr |=> !rd_valid)
    else $error("write produced a read answer");
  a_rd_dir: assert property (cal_rd |-> ctrl_rdsel == 2'h2)
    else $error("read without calibration read select");
  a_single_repeat: assert property (rd_valid && clean_q && ctrl_sel[1] |-> rd_data == last_q)
    else $error("single register read moved");
  c_full_read: cover property (rd_valid && ctrl_sel == 2'h0);
  c_gain_write: cover property (cal_wr && ctrl_sel == 2'h3);
  c_repeat: cover property (rd_valid && clean_q);
endmodule
`default_nettype wire

// *** testbench/adc_calibration_register_access_bench.sv ***
// Self-checking bench: host controller driving the calibration register bank
`timescale 1ns/1ps
`default_nettype none
`include "cal_defines.svh"
module adc_calibration_register_access_bench;
  import cal_pkg::*;
  logic         clk_sys, rst, req_valid, req_mode1, cal_upd_valid, err_q;
  logic         req_ready, rsp_valid, req_err, mode1;
  logic [1:0]   req_op, req_sel, cal_select, read_select;
  logic [3:0]   cal_upd_idx, cal_ptr;
  logic [13:0]  req_wdata, cal_upd_data, rsp_data, gain_trim, offset_trim;
  logic [13:0]  w [10];
  logic [111:0] dac_trim;
  int           fail_count, n_tests, cyc;
  cal_if link ();
  cal_regs_dev i_cal_regs_dev (.clk_sys, .rst, .link(link.dev), .cal_upd_valid, .cal_upd_idx,
    .cal_upd_data, .gain_trim, .offset_trim, .dac_trim, .cal_select, .read_select,
    .mode1, .cal_ptr);
  cal_host i_cal_host (.clk_sys, .rst, .link(link.host), .req_valid, .req_ready, .req_op,
    .req_sel, .req_mode1, .req_wdata, .rsp_valid, .rsp_data, .req_err);
  cal_asserts i_cal_asserts (.clk_sys, .rst, .ctrl_wr(link.ctrl_wr), .ctrl_sel(link.ctrl_sel),
    .ctrl_rdsel(link.ctrl_rdsel), .ctrl_mode1(link.ctrl_mode1), .cal_wr(link.cal_wr),
    .cal_wdata(link.cal_wdata), .cal_rd(link.cal_rd), .rd_valid(link.rd_valid),
    .rd_data(link.rd_data));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Ends at the edge after the take, where the refusal flag is visible
  task automatic issue(input logic [1:0] op, input logic [1:0] sel, input logic m1,
                       input logic [13:0] wd);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_op <= op;
    req_sel <= sel;
    req_mode1 <= m1;
    req_wdata <= wd;
    @(posedge clk_sys);
    while (req_ready !== 1'b1 && n < 20)
    begin
      @(posedge clk_sys);
      n++;
    end
    req_valid <= 1'b0;
    @(posedge clk_sys);
    err_q = req_err;
  endtask
  task automatic rd(input logic [13:0] exp);
    int n;
    n = 0;
    issue(2'h3, 2'h0, 1'b0, 14'h0);
    while (rsp_valid !== 1'b1 && n < 8)
    begin
      @(posedge clk_sys);
      n++;
    end
    check("rsp_data", rsp_data, exp);
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      fail_count++;
      give_verdict();
    end
  end
  initial
  begin
    {rst, req_valid, req_mode1, cal_upd_valid, req_op, req_sel} = 8'h80;
    {cal_upd_idx, req_wdata, cal_upd_data} = 32'h0;
    for (int k = 0; k < 10; k++)
      w[k] = 14'h3f00 + 14'(k);
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check("gain", gain_trim, 14'h2000);
    check("offset", offset_trim, 14'h2000);
    check("ptr", cal_ptr, 4'h0);
    issue(2'h0, 2'h0, 1'b0, 14'h0);
    for (int k = 0; k < 10; k++)
      issue(2'h2, 2'h0, 1'b0, w[k]);
    @(posedge clk_sys);
    check("gain", gain_trim, w[0]);
    check("offset", offset_trim, w[1]);
    check("dac0", dac_trim[13:0], w[2]);
    check("dac7", dac_trim[111:98], w[9]);
    check("ptr", cal_ptr, 4'h0);
    issue(2'h1, 2'h0, 1'b0, 14'h0);
    for (int k = 0; k < 10; k++)
      rd(w[k]);
    issue(2'h0, 2'h1, 1'b0, 14'h0);
    issue(2'h2, 2'h0, 1'b0, 14'h1111);
    issue(2'h2, 2'h0, 1'b0, 14'h2222);
    issue(2'h1, 2'h1, 1'b0, 14'h0);
    rd(14'h1111);
    check("ptr", cal_ptr, 4'h1);
    rd(14'h2222);
    issue(2'h1, 2'h2, 1'b0, 14'h0);
    rd(14'h2222);
    issue(2'h1, 2'h3, 1'b0, 14'h0);
    rd(14'h1111);
    rd(14'h1111);
    issue(2'h1, 2'h0, 1'b0, 14'h0);
    rd(14'h1111);
    rd(14'h2222);
    rd(w[2]);
    issue(2'h1, 2'h0, 1'b0, 14'h0);
    rd(14'h1111);
    issue(2'h2, 2'h0, 1'b0, 14'h5);
    check("err", err_q, 1'b1);
    issue(2'h1, 2'h1, 1'b1, 14'h0);
    @(posedge clk_sys);
    check("mode1", mode1, 1'b1);
    check("read_select", read_select, 2'h2);
    check("cal_select", cal_select, 2'h1);
    rd(14'h1111);
    check("mode1", mode1, 1'b0);
    issue(2'h1, 2'h1, 1'b0, 14'h0);
    check("err", err_q, 1'b1);
    rd(14'h2222);
    issue(2'h1, 2'h1, 1'b0, 14'h0);
    check("err", err_q, 1'b0);
    cal_upd_valid <= 1'b1;
    cal_upd_idx <= 4'h1;
    cal_upd_data <= 14'h0abc;
    @(posedge clk_sys);
    cal_upd_valid <= 1'b0;
    @(posedge clk_sys);
    check("offset", offset_trim, 14'h0abc);
    issue(2'h1, 2'h2, 1'b0, 14'h0);
    rd(14'h0abc);
    give_verdict();
  end
endmodule
`default_nettype wire
